// ==== src/ser_status_top.sv ====
// status event register bank: standard, operation, measurement, questionable
// Functional notes
// - operation complete only after query and idle ops
// - query error on read of empty queue
// - device error when own operation fails
// - execution error on fault during accepted command
// - command error on syntax, semantic, embedded trigger
// - user request on front panel local key
// - power on flag after power restored
// - measuring and trigger wait flags
// - filter settled when settled or filter off
// - idle flag while in idle state
// - unused operation bits carry no event
// - overflow when reading beyond range
// - four limit flags on limit reached
// - reading available after reading processed
// - buffer notify at programmed count
// - buffer available with two or more readings
// - half full and full buffer flags
// - overflow when full buffer wraps
// - hardware limit flag beyond hardware limit
// - quarter, three quarter flags; host avoids tiny buffers
// - master limit when any limit reached
// - four separate event register sets
// - flags latch; reading clears the register
// - summary is OR of enabled flags
// - clear at power up and clear status
`timescale 1ns/1ps
module ser_status_top (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// command handling events
	input wire logic op_done_query_i,
	input wire logic ops_pending_i,
	input wire logic response_read_i,
	input wire logic out_queue_empty_i,
	input wire logic device_fault_i,
	input wire logic exec_fault_i,
	input wire logic syntax_error_i,
	input wire logic semantic_error_i,
	input wire logic trigger_in_msg_i,
	input wire logic clear_status_i,
	// front panel pin
	input wire logic local_key_i,
	// operation conditions
	input wire logic measuring_i,
	input wire logic trig_wait_i,
	input wire logic filter_settled_i,
	input wire logic filter_off_i,
	input wire logic idle_i,
	// measurement conditions
	input wire logic reading_overflow_i,
	input wire logic [3:0] limit_hit_i,
	input wire logic reading_done_i,
	input wire logic hw_limit_i,
	input wire logic [ser_pkg::CNT_W-1:0] buf_count_i,
	input wire logic [ser_pkg::CNT_W-1:0] buf_size_i,
	input wire logic [ser_pkg::CNT_W-1:0] buf_notify_i,
	input wire logic buf_wrap_i,
	// questionable conditions
	input wire logic temp_invalid_i,
	input wire logic cal_invalid_i,
	input wire logic cmd_warning_i,
	// host reads and enables
	input wire ser_pkg::ser_rd_s rd_i,
	input wire logic [ser_pkg::STD_W-1:0] std_enable_i,
	input wire logic [ser_pkg::OP_W-1:0] op_enable_i,
	input wire logic [ser_pkg::MEAS_W-1:0] meas_enable_i,
	input wire logic [ser_pkg::QUES_W-1:0] ques_enable_i,
	// read answers
	output logic [ser_pkg::STD_W-1:0] std_data_o,
	output logic [ser_pkg::OP_W-1:0] op_data_o,
	output logic [ser_pkg::MEAS_W-1:0] meas_data_o,
	output logic [ser_pkg::QUES_W-1:0] ques_data_o,
	output logic rd_valid_o,
	// summaries toward the status byte
	output logic std_summary_o,
	output logic op_summary_o,
	output logic meas_summary_o,
	output logic ques_summary_o
);

	ser_pkg::ser_done_e done_q, done_d;
	logic key_meta_q, key_sync_q;
	logic power_on_q, power_on_d;
	logic rd_valid_q, rd_valid_d;
	logic done_fire;
	logic [ser_pkg::STD_W-1:0] std_cond, std_flags;
	logic [ser_pkg::OP_W-1:0] op_cond, op_flags;
	logic [ser_pkg::MEAS_W-1:0] meas_cond, meas_flags;
	logic [ser_pkg::QUES_W-1:0] ques_cond, ques_flags;
	ser_pkg::ser_fill_s fill;

	// front panel key is asynchronous
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			key_meta_q <= 1'b0;
			key_sync_q <= 1'b0;
		end else begin
			key_meta_q <= local_key_i;
			key_sync_q <= key_meta_q;
		end
	end

	// operation complete waits for pending work
	always_comb begin
		done_d = done_q;
		done_fire = 1'b0;
		unique case (done_q)
			ser_pkg::SER_DONE_IDLE: begin
				if (op_done_query_i && ops_pending_i) begin
					done_d = ser_pkg::SER_DONE_WAIT;
				end else if (op_done_query_i) begin
					done_fire = 1'b1;
				end
			end
			ser_pkg::SER_DONE_WAIT: begin
				if (!ops_pending_i) begin
					done_fire = 1'b1;
					done_d = ser_pkg::SER_DONE_IDLE;
				end
			end
			default: begin
				done_d = ser_pkg::SER_DONE_IDLE;
			end
		endcase
	end

	// power-on mark drops after the first edge, giving one flag edge
	always_comb begin
		power_on_d = 1'b0;
		rd_valid_d = rd_i.std || rd_i.op || rd_i.meas || rd_i.ques;
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			done_q <= ser_pkg::SER_DONE_IDLE;
			power_on_q <= 1'b1;
			rd_valid_q <= 1'b0;
		end else begin
			done_q <= done_d;
			power_on_q <= power_on_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	ser_fill_level u_fill (
		.count_i(buf_count_i),
		.size_i(buf_size_i),
		.notify_i(buf_notify_i),
		.fill_o(fill)
	);

	// event conditions per register
	always_comb begin
		std_cond = '0;
		std_cond[ser_pkg::STD_OPDONE_BIT] = done_fire;
		std_cond[ser_pkg::STD_QUERY_ERR_BIT] = response_read_i && out_queue_empty_i;
		std_cond[ser_pkg::STD_DEV_ERR_BIT] = device_fault_i;
		std_cond[ser_pkg::STD_EXEC_ERR_BIT] = exec_fault_i;
		std_cond[ser_pkg::STD_CMD_ERR_BIT] = syntax_error_i || semantic_error_i || trigger_in_msg_i;
		std_cond[ser_pkg::STD_USER_REQ_BIT] = key_sync_q;
		std_cond[ser_pkg::STD_POWER_ON_BIT] = power_on_q;
		op_cond = '0;
		op_cond[ser_pkg::OP_MEAS_BIT] = measuring_i;
		op_cond[ser_pkg::OP_TRIG_BIT] = trig_wait_i;
		op_cond[ser_pkg::OP_FILT_BIT] = filter_settled_i || filter_off_i;
		op_cond[ser_pkg::OP_IDLE_BIT] = idle_i;
		meas_cond = '0;
		meas_cond[ser_pkg::MEAS_OVER_BIT] = reading_overflow_i;
		meas_cond[ser_pkg::MEAS_LIM_LSB +: 4] = limit_hit_i;
		meas_cond[ser_pkg::MEAS_READY_BIT] = reading_done_i;
		meas_cond[ser_pkg::MEAS_NOTIFY_BIT] = fill.notify;
		meas_cond[ser_pkg::MEAS_AVAIL_BIT] = fill.avail;
		meas_cond[ser_pkg::MEAS_HALF_BIT] = fill.half;
		meas_cond[ser_pkg::MEAS_FULL_BIT] = fill.full;
		meas_cond[ser_pkg::MEAS_WRAP_BIT] = buf_wrap_i && fill.full;
		meas_cond[ser_pkg::MEAS_HWL_BIT] = hw_limit_i;
		meas_cond[ser_pkg::MEAS_QUARTER_BIT] = fill.quarter;
		meas_cond[ser_pkg::MEAS_THREE_Q_BIT] = fill.three_q;
		meas_cond[ser_pkg::MEAS_MASTER_BIT] = (|limit_hit_i) || hw_limit_i;
		ques_cond = '0;
		ques_cond[ser_pkg::QUES_TEMP_BIT] = temp_invalid_i;
		ques_cond[ser_pkg::QUES_CAL_BIT] = cal_invalid_i;
		ques_cond[ser_pkg::QUES_WARN_BIT] = cmd_warning_i;
	end

	// four independent register sets
	ser_event_reg #(.W(ser_pkg::STD_W), .USED(ser_pkg::STD_USED), .RST(ser_pkg::STD_RST)) u_std (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.cond_i(std_cond),
		.rd_i(rd_i.std),
		.clr_i(clear_status_i),
		.enable_i(std_enable_i),
		.flags_o(std_flags),
		.rd_data_o(std_data_o),
		.summary_o(std_summary_o)
	);

	ser_event_reg #(.W(ser_pkg::OP_W), .USED(ser_pkg::OP_USED), .RST(ser_pkg::OP_RST)) u_op (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.cond_i(op_cond),
		.rd_i(rd_i.op),
		.clr_i(clear_status_i),
		.enable_i(op_enable_i),
		.flags_o(op_flags),
		.rd_data_o(op_data_o),
		.summary_o(op_summary_o)
	);

	ser_event_reg #(.W(ser_pkg::MEAS_W), .USED(ser_pkg::MEAS_USED), .RST(ser_pkg::MEAS_RST)) u_meas (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.cond_i(meas_cond),
		.rd_i(rd_i.meas),
		.clr_i(clear_status_i),
		.enable_i(meas_enable_i),
		.flags_o(meas_flags),
		.rd_data_o(meas_data_o),
		.summary_o(meas_summary_o)
	);

	ser_event_reg #(.W(ser_pkg::QUES_W), .USED(ser_pkg::QUES_USED), .RST(ser_pkg::QUES_RST)) u_ques (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.cond_i(ques_cond),
		.rd_i(rd_i.ques),
		.clr_i(clear_status_i),
		.enable_i(ques_enable_i),
		.flags_o(ques_flags),
		.rd_data_o(ques_data_o),
		.summary_o(ques_summary_o)
	);

	assign rd_valid_o = rd_valid_q;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	property p_done_cause;
		$rose(std_flags[ser_pkg::STD_OPDONE_BIT]) |-> $past(done_fire);
	endproperty
	a_done_cause: assert property (p_done_cause) else $error("done flag set without query");

	property p_done_wait;
		(done_q == ser_pkg::SER_DONE_WAIT && ops_pending_i) |-> !done_fire;
	endproperty
	a_done_wait: assert property (p_done_wait) else $error("done fired with ops pending");

	property p_query_err;
		$rose(response_read_i && out_queue_empty_i) |=> std_flags[ser_pkg::STD_QUERY_ERR_BIT];
	endproperty
	a_query_err: assert property (p_query_err) else $error("query error not flagged");

	property p_user_req;
		$rose(key_sync_q) |=> std_flags[ser_pkg::STD_USER_REQ_BIT];
	endproperty
	a_user_req: assert property (p_user_req) else $error("local key not flagged");

	property p_power_on;
		$fell(power_on_q) |-> std_flags[ser_pkg::STD_POWER_ON_BIT];
	endproperty
	a_power_on: assert property (p_power_on) else $error("power on flag missing");

	property p_filt;
		$rose(filter_settled_i || filter_off_i) |=> op_flags[ser_pkg::OP_FILT_BIT];
	endproperty
	a_filt: assert property (p_filt) else $error("filter settled not flagged");

	property p_op_unused;
		(op_flags & ~ser_pkg::OP_USED) == '0;
	endproperty
	a_op_unused: assert property (p_op_unused) else $error("unused operation bit set");

	property p_ques_unused;
		(ques_flags & ~ser_pkg::QUES_USED) == '0;
	endproperty
	a_ques_unused: assert property (p_ques_unused) else $error("unused questionable bit set");

	property p_buf_avail;
		$rose(fill.avail) |=> meas_flags[ser_pkg::MEAS_AVAIL_BIT];
	endproperty
	a_buf_avail: assert property (p_buf_avail) else $error("buffer available not flagged");

	property p_master_limit;
		$rose((|limit_hit_i) || hw_limit_i) |=> meas_flags[ser_pkg::MEAS_MASTER_BIT];
	endproperty
	a_master_limit: assert property (p_master_limit) else $error("master limit not flagged");

	property p_rd_data;
		rd_i.std |=> (std_data_o == $past(std_flags)) && rd_valid_o;
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("standard read data wrong");

	property p_cls;
		(clear_status_i && std_cond == '0) ##1 (std_cond == '0) |-> std_flags == '0;
	endproperty
	a_cls: assert property (p_cls) else $error("clear status left flags");

	property p_summary;
		meas_summary_o == |(meas_flags & meas_enable_i);
	endproperty
	a_summary: assert property (p_summary) else $error("measurement summary wrong");

	c_done_wait: cover property (done_q == ser_pkg::SER_DONE_WAIT ##[1:20] done_fire);
	c_full: cover property ($rose(meas_flags[ser_pkg::MEAS_FULL_BIT]));
	c_read_set: cover property (rd_i.meas && meas_flags != '0);
	c_wrap: cover property ($rose(meas_flags[ser_pkg::MEAS_WRAP_BIT]));

endmodule

// ==== src/ser_pkg.sv ====
// shared constants and types of the status event register bank
package ser_pkg;

	// register widths
	localparam int STD_W = 8;
	localparam int OP_W = 16;
	localparam int MEAS_W = 16;
	localparam int QUES_W = 16;
	localparam int CNT_W = 16;

	// standard event bit positions
	localparam int STD_OPDONE_BIT = 0;
	localparam int STD_QUERY_ERR_BIT = 2;
	localparam int STD_DEV_ERR_BIT = 3;
	localparam int STD_EXEC_ERR_BIT = 4;
	localparam int STD_CMD_ERR_BIT = 5;
	localparam int STD_USER_REQ_BIT = 6;
	localparam int STD_POWER_ON_BIT = 7;

	// operation event bit positions
	localparam int OP_MEAS_BIT = 4;
	localparam int OP_TRIG_BIT = 5;
	localparam int OP_FILT_BIT = 8;
	localparam int OP_IDLE_BIT = 10;

	// measurement event bit positions
	localparam int MEAS_OVER_BIT = 0;
	localparam int MEAS_LIM_LSB = 1;
	localparam int MEAS_READY_BIT = 5;
	localparam int MEAS_NOTIFY_BIT = 6;
	localparam int MEAS_AVAIL_BIT = 7;
	localparam int MEAS_HALF_BIT = 8;
	localparam int MEAS_FULL_BIT = 9;
	localparam int MEAS_WRAP_BIT = 10;
	localparam int MEAS_HWL_BIT = 11;
	localparam int MEAS_QUARTER_BIT = 12;
	localparam int MEAS_THREE_Q_BIT = 13;
	localparam int MEAS_MASTER_BIT = 14;

	// questionable event bit positions
	localparam int QUES_TEMP_BIT = 4;
	localparam int QUES_CAL_BIT = 8;
	localparam int QUES_WARN_BIT = 14;

	// bits that carry an event; all others read zero
	localparam logic [STD_W-1:0] STD_USED = 8'hFD;
	localparam logic [OP_W-1:0] OP_USED = 16'h0530;
	localparam logic [MEAS_W-1:0] MEAS_USED = 16'h7FFF;
	localparam logic [QUES_W-1:0] QUES_USED = 16'h4110;

	// reset values
	localparam logic [STD_W-1:0] STD_RST = 8'h00;
	localparam logic [OP_W-1:0] OP_RST = 16'h0000;
	localparam logic [MEAS_W-1:0] MEAS_RST = 16'h0000;
	localparam logic [QUES_W-1:0] QUES_RST = 16'h0000;

	// least stored readings for buffer available
	localparam logic [CNT_W-1:0] BUF_AVAIL_MIN = 16'h0002;

	typedef enum logic [1:0] {
		SER_DONE_IDLE = 2'h1,
		SER_DONE_WAIT = 2'h2
	} ser_done_e;

	typedef struct packed {
		logic std;
		logic op;
		logic meas;
		logic ques;
	} ser_rd_s;

	typedef struct packed {
		logic notify;
		logic avail;
		logic half;
		logic full;
		logic quarter;
		logic three_q;
	} ser_fill_s;

endpackage

// ==== src/ser_event_reg.sv ====
// one latched event register with edge set, clearing read and summary
`timescale 1ns/1ps
module ser_event_reg #(
	parameter int W = 16,
	parameter logic [W-1:0] USED = '1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// event conditions and host control
	input wire logic [W-1:0] cond_i,
	input wire logic rd_i,
	input wire logic clr_i,
	input wire logic [W-1:0] enable_i,
	// state and answers
	output logic [W-1:0] flags_o,
	output logic [W-1:0] rd_data_o,
	output logic summary_o
);

	logic [W-1:0] flags_q, flags_d;
	logic [W-1:0] prev_q, prev_d;
	logic [W-1:0] data_q, data_d;
	logic [W-1:0] set_w;

	always_comb begin
		set_w = cond_i & ~prev_q & USED;
		prev_d = cond_i;
		// a set in the clearing cycle survives
		flags_d = (((rd_i || clr_i) ? RST : flags_q) | set_w) & USED;
		data_d = rd_i ? flags_q : data_q;
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flags_q <= RST;
			prev_q <= '0;
			data_q <= '0;
		end else begin
			flags_q <= flags_d;
			prev_q <= prev_d;
			data_q <= data_d;
		end
	end

	assign flags_o = flags_q;
	assign rd_data_o = data_q;
	assign summary_o = |(flags_q & enable_i);

	property p_latch;
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		!(rd_i || clr_i) |=> ((flags_q & $past(flags_q)) == $past(flags_q));
	endproperty
	a_latch: assert property (p_latch) else $error("event flag dropped without clear");

	property p_set_wins;
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(rd_i && (|set_w)) |=> ((flags_q & $past(set_w)) == $past(set_w));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost in clearing read");

	property p_no_reset;
		@(posedge ref_clk_i) disable iff (!arst_n_i)
		(rd_i && !clr_i && ((cond_i & prev_q) != '0)) |=> ((flags_q & $past(cond_i & prev_q)) == '0);
	endproperty
	a_no_reset: assert property (p_no_reset) else $error("steady condition set flag again");

endmodule

// ==== src/ser_fill_level.sv ====
// reading buffer fill level decode
`timescale 1ns/1ps
module ser_fill_level (
	// buffer state
	input wire logic [ser_pkg::CNT_W-1:0] count_i,
	input wire logic [ser_pkg::CNT_W-1:0] size_i,
	input wire logic [ser_pkg::CNT_W-1:0] notify_i,
	// levels reached
	output ser_pkg::ser_fill_s fill_o
);

	logic [ser_pkg::CNT_W+1:0] three_w;

	// zero threshold means the level is not armed
	function automatic logic reached(input logic [ser_pkg::CNT_W-1:0] cnt,
		input logic [ser_pkg::CNT_W-1:0] thr);
		reached = (thr != '0) && (cnt >= thr);
	endfunction

	always_comb begin
		three_w = ({2'h0, size_i} << 1) + {2'h0, size_i};
		fill_o.notify = (notify_i != '0) && (count_i == notify_i);
		fill_o.avail = count_i >= ser_pkg::BUF_AVAIL_MIN;
		fill_o.half = reached(count_i, size_i >> 1);
		fill_o.full = reached(count_i, size_i);
		fill_o.quarter = reached(count_i, size_i >> 2);
		fill_o.three_q = reached(count_i, three_w[ser_pkg::CNT_W+1:2]);
	end

endmodule

// ==== dv/ser_host_model.sv ====
// host controller model issuing event register reads
`timescale 1ns/1ps
module ser_host_model (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// read request from the bench
	input wire logic req_i,
	input wire logic [1:0] sel_i,
	input wire logic [3:0] wait_i,
	output logic done_o,
	// read strobes toward the device
	output ser_pkg::ser_rd_s rd_o
);
	initial begin
		rd_o = '0;
		done_o = 1'b0;
		forever begin
			@(posedge ref_clk_i);
			if (req_i && arst_n_i) begin
				// slow host: idle cycles before the query
				repeat (wait_i) @(posedge ref_clk_i);
				#10;
				// one query at a time, one register per query
				rd_o = ser_pkg::ser_rd_s'(4'h8 >> sel_i);
				@(posedge ref_clk_i);
				#10;
				rd_o = '0;
				done_o = 1'b1;
				@(posedge ref_clk_i);
				#10;
				done_o = 1'b0;
			end
		end
	end
endmodule

// ==== dv/ser_status_top_tb_top.sv ====
// self-checking bench for the status event register bank
`timescale 1ns/1ps
module ser_status_top_tb_top;
	logic ref_clk_i;
	logic arst_n_i;
	logic [24:0] ev;
	logic ops_pending;
	logic queue_empty;
	logic [15:0] cnt;
	logic [15:0] size;
	logic [15:0] notify;
	logic [7:0] std_en;
	logic [15:0] op_en;
	logic [15:0] meas_en;
	logic [15:0] ques_en;
	logic req;
	logic [1:0] sel;
	logic [3:0] slow;
	logic done;
	ser_pkg::ser_rd_s rd;
	logic [7:0] std_data;
	logic [15:0] op_data;
	logic [15:0] meas_data;
	logic [15:0] ques_data;
	logic rd_valid;
	wire logic [3:0] summ;
	logic [17:0] exp_q[$];
	logic [17:0] note;
	logic [31:0] seed;
	int errors;
	int check_count;

	ser_status_top dut (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.op_done_query_i(ev[0]),
		.ops_pending_i(ops_pending),
		.response_read_i(ev[1]),
		.out_queue_empty_i(queue_empty),
		.device_fault_i(ev[2]),
		.exec_fault_i(ev[3]),
		.syntax_error_i(ev[4]),
		.semantic_error_i(ev[5]),
		.trigger_in_msg_i(ev[6]),
		.clear_status_i(ev[7]),
		.local_key_i(ev[8]),
		.measuring_i(ev[9]),
		.trig_wait_i(ev[10]),
		.filter_settled_i(ev[11]),
		.filter_off_i(ev[12]),
		.idle_i(ev[13]),
		.reading_overflow_i(ev[14]),
		.limit_hit_i(ev[24:21]),
		.reading_done_i(ev[15]),
		.hw_limit_i(ev[16]),
		.buf_count_i(cnt),
		.buf_size_i(size),
		.buf_notify_i(notify),
		.buf_wrap_i(ev[17]),
		.temp_invalid_i(ev[18]),
		.cal_invalid_i(ev[19]),
		.cmd_warning_i(ev[20]),
		.rd_i(rd),
		.std_enable_i(std_en),
		.op_enable_i(op_en),
		.meas_enable_i(meas_en),
		.ques_enable_i(ques_en),
		.std_data_o(std_data),
		.op_data_o(op_data),
		.meas_data_o(meas_data),
		.ques_data_o(ques_data),
		.rd_valid_o(rd_valid),
		.std_summary_o(summ[3]),
		.op_summary_o(summ[2]),
		.meas_summary_o(summ[1]),
		.ques_summary_o(summ[0])
	);

	ser_host_model host (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.req_i(req),
		.sel_i(sel),
		.wait_i(slow),
		.done_o(done),
		.rd_o(rd)
	);

	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic check(logic [15:0] seen, logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("checks %0d errors %0d pending %0d", check_count, errors, exp_q.size());
		if (errors == 0 && check_count > 0 && exp_q.size() == 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic step(int n);
		repeat (n) @(posedge ref_clk_i);
		#10;
	endtask

	task automatic host_read(logic [1:0] s, logic [15:0] exp);
		int k;
		exp_q.push_back({s, exp});
		seed = xs(seed);
		sel = s;
		slow = {2'h0, seed[1:0]};
		req = 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk_i);
			k++;
		end while (done !== 1'b1 && k < 20);
		#10;
		req = 1'b0;
		step(1);
	endtask

	task automatic ev_chk(int i, logic [1:0] s, logic [15:0] exp);
		ev[i] = 1'b1;
		step(1);
		ev[i] = 1'b0;
		step(4);
		host_read(s, exp);
	endtask

	task automatic buf_chk(logic [15:0] c, logic [15:0] exp);
		cnt = c;
		step(3);
		host_read(2'h2, exp);
	endtask

	// oldest note against each read answer
	always @(negedge ref_clk_i) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(16'hFFFF, 16'h0000);
			end else begin
				note = exp_q.pop_front();
				case (note[17:16])
					2'h0: check({8'h00, std_data}, note[15:0]);
					2'h1: check(op_data, note[15:0]);
					2'h2: check(meas_data, note[15:0]);
					default: check(ques_data, note[15:0]);
				endcase
			end
		end
	end

	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	initial begin
		repeat (5000) @(posedge ref_clk_i);
		errors++;
		final_report;
	end

	initial begin
		arst_n_i = 1'b0;
		ev = '0;
		ops_pending = 1'b0;
		queue_empty = 1'b0;
		cnt = 16'h0000;
		size = 16'h0008;
		notify = 16'h0006;
		std_en = 8'h00;
		op_en = 16'h0000;
		meas_en = 16'h0000;
		ques_en = 16'h0000;
		req = 1'b0;
		sel = 2'h0;
		slow = 4'h0;
		errors = 0;
		check_count = 0;
		seed = 32'd47;
		repeat (6) @(posedge ref_clk_i);
		#10;
		arst_n_i = 1'b1;
		step(2);
		host_read(2'h0, 16'h0080);
		host_read(2'h0, 16'h0000);
		ev_chk(0, 2'h0, 16'h0001);
		ops_pending = 1'b1;
		ev_chk(0, 2'h0, 16'h0000);
		ops_pending = 1'b0;
		step(2);
		host_read(2'h0, 16'h0001);
		ev_chk(1, 2'h0, 16'h0000);
		queue_empty = 1'b1;
		ev_chk(1, 2'h0, 16'h0004);
		ev_chk(2, 2'h0, 16'h0008);
		ev_chk(3, 2'h0, 16'h0010);
		for (int i = 4; i < 7; i++) ev_chk(i, 2'h0, 16'h0020);
		ev_chk(8, 2'h0, 16'h0040);
		ev_chk(9, 2'h1, 16'h0010);
		ev_chk(10, 2'h1, 16'h0020);
		ev_chk(11, 2'h1, 16'h0100);
		ev_chk(12, 2'h1, 16'h0100);
		ev_chk(13, 2'h1, 16'h0400);
		ev_chk(14, 2'h2, 16'h0001);
		for (int i = 0; i < 4; i++) ev_chk(21 + i, 2'h2, 16'h4000 | (16'h0002 << i));
		ev_chk(15, 2'h2, 16'h0020);
		ev_chk(16, 2'h2, 16'h4800);
		ev_chk(18, 2'h3, 16'h0010);
		ev_chk(19, 2'h3, 16'h0100);
		ev_chk(20, 2'h3, 16'h4000);
		// fill levels of an eight-reading buffer, notify at six
		buf_chk(16'h0001, 16'h0000);
		buf_chk(16'h0002, 16'h1080);
		buf_chk(16'h0004, 16'h0100);
		buf_chk(16'h0006, 16'h2040);
		buf_chk(16'h0008, 16'h0200);
		ev_chk(17, 2'h2, 16'h0400);
		cnt = 16'h0000;
		ev_chk(17, 2'h2, 16'h0000);
		// summaries under random enables
		ev = 25'h0000204;
		step(1);
		ev = '0;
		step(2);
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			std_en = seed[7:0];
			op_en = seed[23:8];
			meas_en = seed[31:16];
			ques_en = ~seed[15:0];
			step(1);
			check({12'h000, summ}, {12'h000, |(seed[7:0] & 8'h08), |(seed[23:8] & 16'h0010), 2'h0});
		end
		host_read(2'h0, 16'h0008);
		host_read(2'h1, 16'h0010);
		check({12'h000, summ}, 16'h0000);
		// condition held high sets once
		ev[3] = 1'b1;
		step(2);
		host_read(2'h0, 16'h0010);
		host_read(2'h0, 16'h0000);
		ev[3] = 1'b0;
		// event in the same cycle as the clearing read
		fork
			host_read(2'h0, 16'h0000);
			begin
				@(posedge rd.std);
				ev[3] = 1'b1;
				step(1);
				ev[3] = 1'b0;
			end
		join
		host_read(2'h0, 16'h0010);
		// clear status wipes pending flags
		ev = 25'h0000204;
		step(1);
		ev = 25'h0000080;
		step(1);
		ev = '0;
		step(2);
		host_read(2'h0, 16'h0000);
		host_read(2'h1, 16'h0000);
		step(4);
		final_report;
	end
endmodule
